/* common/pidsw_pkg.sv */
/*
 * pidsw_pkg: constants and types of the pid loop with sleep and wake.
 * assumes: a 10 MHz core clock; all frequencies in 0.01 Hz, all percents in 0.1 %.
 */
package pidsw_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS    = 100;
    localparam int unsigned SAMPLE_PERIOD_NS = 1_000_000;
    localparam int unsigned SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // widths and scales
    // ------------------------------------------------------------------
    localparam int unsigned VAL_W = 16;
    localparam int unsigned ERR_W = 24;
    localparam int unsigned ACC_W = 40;
    localparam logic [15:0] PCT_FULL_SCALE    = 16'h03E8;  // 100.0 %
    localparam logic [15:0] MS_PER_TIME_STEP  = 16'h000A;  // loop times count 0.01 s
    localparam logic [15:0] MS_PER_SLEEP_STEP = 16'h0064;  // sleep delay counts 0.1 s

    // ------------------------------------------------------------------
    // codes
    // ------------------------------------------------------------------
    localparam logic [4:0] FUNC_LOOP_BYPASS = 5'h15;
    localparam logic [2:0] SP_SRC_LOCAL     = 3'h0;
    localparam int unsigned TERM_COUNT      = 5;

    typedef enum logic [1:0] {
        PIDSW_FB_CURRENT = 2'b00,
        PIDSW_FB_TERM_V  = 2'b01,
        PIDSW_FB_VOLTAGE = 2'b10,
        PIDSW_FB_SERIAL  = 2'b11
    } pidsw_fb_src_t;

    typedef enum logic [1:0] {
        PIDSW_ST_IDLE  = 2'b00,
        PIDSW_ST_START = 2'b01,
        PIDSW_ST_DIV   = 2'b10
    } pidsw_state_t;

endpackage : pidsw_pkg

/* core/pidsw_tick.sv */
/*
 * pidsw_tick: one-cycle sample tick every PERIOD core clocks.
 * assumes: sync_reset_i comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pidsw_tick #(
    parameter int unsigned PERIOD = pidsw_pkg::SAMPLE_CYCLES
) (
    input  wire logic core_clk_i,
    input  wire logic resetn_i,
    input  wire logic sync_reset_i,
    output logic      tick_o
);
    logic [23:0] cnt_q;
    logic [23:0] cnt_d;
    logic        tick_d;

    always_comb begin
        tick_d = 1'b0;
        cnt_d  = cnt_q + 24'h00_0001;
        if (sync_reset_i) begin
            cnt_d = 24'h00_0000;
        end else if (cnt_q == 24'(PERIOD - 1)) begin
            cnt_d  = 24'h00_0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q  <= 24'h00_0000;
            tick_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_o <= tick_d;
        end
    end

    a_tick_spacing: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        tick_o |=> !tick_o [*8]) else $error("sample ticks closer than expected");
endmodule : pidsw_tick
`default_nettype wire

/* core/pidsw_div.sv */
/*
 * pidsw_div: unsigned restoring divider, one quotient bit per clock.
 * assumes: start_i is a one-cycle pulse and is not raised while busy.
 */
`timescale 1ns/1ps
`default_nettype none
module pidsw_div #(
    parameter int unsigned NW = 40,
    parameter int unsigned DW = 16
) (
    input  wire logic          core_clk_i,
    input  wire logic          resetn_i,
    input  wire logic          start_i,
    input  wire logic [NW-1:0] num_i,
    input  wire logic [DW-1:0] den_i,
    output logic               done_o,
    output logic [NW-1:0]      quo_o
);
    logic [NW-1:0] quo_d;
    logic [DW:0]   rem_q, rem_d, trial;
    logic [DW-1:0] den_q, den_d;
    logic [7:0]    cnt_q, cnt_d;
    logic          done_d;

    always_comb begin
        quo_d  = quo_o;
        rem_d  = rem_q;
        den_d  = den_q;
        cnt_d  = cnt_q;
        done_d = 1'b0;
        trial  = {rem_q[DW-1:0], quo_o[NW-1]} - {1'b0, den_q};
        if (start_i) begin
            quo_d = num_i;
            rem_d = '0;
            den_d = (den_i == '0) ? DW'(1) : den_i;  // zero divisor acts as one
            cnt_d = 8'(NW);
        end else if (cnt_q != 8'h00) begin
            if (!trial[DW]) begin
                rem_d = trial;
                quo_d = {quo_o[NW-2:0], 1'b1};
            end else begin
                rem_d = {rem_q[DW-1:0], quo_o[NW-1]};
                quo_d = {quo_o[NW-2:0], 1'b0};
            end
            cnt_d  = cnt_q - 8'h01;
            done_d = (cnt_q == 8'h01);
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            quo_o  <= '0;
            rem_q  <= '0;
            den_q  <= '0;
            cnt_q  <= 8'h00;
            done_o <= 1'b0;
        end else begin
            quo_o  <= quo_d;
            rem_q  <= rem_d;
            den_q  <= den_d;
            cnt_q  <= cnt_d;
            done_o <= done_d;
        end
    end
endmodule : pidsw_div
`default_nettype wire

/* core/pidsw_core.sv */
/*
 * pidsw_core: pid regulator setting output frequency, with bypass, sleep and wake.
 * assumes: configuration ports are static or change slowly on the core clock;
 * analog and serial feedback arrive already scaled to 0.1 % on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pidsw_core #(
    parameter int unsigned SAMPLE_CYCLES = pidsw_pkg::SAMPLE_CYCLES
) (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        sync_reset_i,
    input  wire logic        loop_enable_select_i,
    input  wire logic        loop_mode_select_i,
    input  wire logic        unit_scale_select_i,
    input  wire logic [1:0]  feedback_source_select_i,
    input  wire logic [2:0]  setpoint_source_select_i,
    input  wire logic [15:0] loop_setpoint_i,
    input  wire logic [15:0] ext_setpoint_i,
    input  wire logic [15:0] main_reference_i,
    input  wire logic [15:0] maximum_frequency_setting_i,
    input  wire logic [15:0] current_or_voltage_input_i,
    input  wire logic [15:0] voltage_input_i,
    input  wire logic [15:0] serial_feedback_i,
    input  wire logic [15:0] proportional_gain_i,
    input  wire logic [15:0] integral_time_i,
    input  wire logic [15:0] derivative_time_i,
    input  wire logic [15:0] output_upper_limit_i,
    input  wire logic [15:0] output_lower_limit_i,
    input  wire logic [15:0] sleep_delay_i,
    input  wire logic [15:0] sleep_frequency_i,
    input  wire logic [15:0] wake_level_i,
    input  wire logic [4:0]  multi_function_inputs_i,
    input  wire logic [24:0] input_terminal_function_i,
    input  wire logic        run_cmd_i,
    output logic [15:0]      out_freq_o,
    output logic [15:0]      process_correction_output_o,
    output logic [15:0]      loop_feedback_value_o,
    output logic [15:0]      monitor_o,
    output logic             asleep_o,
    output logic             bypass_o
);
    localparam int unsigned AW = pidsw_pkg::ACC_W;
    localparam int unsigned EW = pidsw_pkg::ERR_W;

    function automatic logic [15:0] pct_to_hz(input logic [15:0] pct, input logic [15:0] maxf);
        logic [31:0] prod;
        prod = (32'(pct) * 32'(maxf)) / 32'(pidsw_pkg::PCT_FULL_SCALE);
        return prod[15:0];
    endfunction : pct_to_hz

    // ------------------------------------------------------------------
    // terminal inputs: pins cross into the core clock
    // ------------------------------------------------------------------
    logic [4:0] pin_s1_q, pin_s2_q;
    wire  [4:0] term_hit;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
        end else begin
            pin_s1_q <= multi_function_inputs_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    for (genvar g = 0; g < pidsw_pkg::TERM_COUNT; g++) begin : g_term
        assign term_hit[g] = pin_s2_q[g] &&
            (input_terminal_function_i[g*5 +: 5] == pidsw_pkg::FUNC_LOOP_BYPASS);
    end

    // ------------------------------------------------------------------
    // sample tick and integral divider
    // ------------------------------------------------------------------
    logic            tick;
    logic            div_done;
    logic [AW-1:0]   div_quo;
    logic [15:0]     ti_ms;
    logic [AW-1:0]   integ_mag;
    pidsw_pkg::pidsw_state_t st_q, st_d;

    pidsw_tick #(.PERIOD(SAMPLE_CYCLES)) u_tick (
        .core_clk_i  (core_clk_i),
        .resetn_i    (resetn_i),
        .sync_reset_i(sync_reset_i),
        .tick_o      (tick)
    );

    pidsw_div #(.NW(AW), .DW(16)) u_div (
        .core_clk_i(core_clk_i),
        .resetn_i  (resetn_i),
        .start_i   (st_q == pidsw_pkg::PIDSW_ST_START),
        .num_i     (integ_mag),
        .den_i     (ti_ms),
        .done_o    (div_done),
        .quo_o     (div_quo)
    );

    // ------------------------------------------------------------------
    // loop state
    // ------------------------------------------------------------------
    logic signed [EW-1:0] err_q, err_d, errp_q, errp_d, err_now;
    logic signed [AW-1:0] integ_q, integ_d;
    logic signed [AW-1:0] p_term, i_term, d_term, pid, corr, psum;
    logic [15:0] loop_out_q, loop_out_d, total_q, total_d, corr_d;
    logic [15:0] fb_pct, fb_hz, sp_raw, sp_hz, up_eff, wake_hz, loop_freq;
    logic [15:0] out_d, fbval_d, mon_d;
    logic [23:0] sleep_cnt_q, sleep_cnt_d, delay_ms;
    logic        sat_q, sat_d, asleep_d, bypass_d, sleep_cond;
    logic [EW-1:0] dev;

    always_comb begin
        case (pidsw_pkg::pidsw_fb_src_t'(feedback_source_select_i))
            pidsw_pkg::PIDSW_FB_CURRENT: fb_pct = current_or_voltage_input_i;
            pidsw_pkg::PIDSW_FB_TERM_V:  fb_pct = current_or_voltage_input_i;
            pidsw_pkg::PIDSW_FB_VOLTAGE: fb_pct = voltage_input_i;
            default:                     fb_pct = serial_feedback_i;
        endcase
        fb_hz   = pct_to_hz(fb_pct, maximum_frequency_setting_i);
        // only the local setpoint is decoded here; sources 1 to 5 share one port
        sp_raw  = (setpoint_source_select_i == pidsw_pkg::SP_SRC_LOCAL) ?
                  loop_setpoint_i : ext_setpoint_i;
        sp_hz   = unit_scale_select_i ?
                  pct_to_hz(sp_raw, maximum_frequency_setting_i) : sp_raw;
        fbval_d = unit_scale_select_i ? fb_pct : fb_hz;
        err_now = EW'($signed({1'b0, sp_hz})) - EW'($signed({1'b0, fb_hz}));
        dev     = err_now[EW-1] ? EW'(-err_now) : EW'(err_now);
        wake_hz = pct_to_hz(wake_level_i, maximum_frequency_setting_i);
        up_eff  = (output_upper_limit_i < output_lower_limit_i) ?
                  output_lower_limit_i : output_upper_limit_i;
        ti_ms   = 16'(integral_time_i * pidsw_pkg::MS_PER_TIME_STEP);
        integ_mag = integ_q[AW-1] ? AW'(-integ_q) : AW'(integ_q);
        bypass_d  = |term_hit;

        p_term = (AW'(err_q) * $signed({24'h00_0000, proportional_gain_i}))
                 / $signed(AW'(pidsw_pkg::PCT_FULL_SCALE));
        i_term = integ_q[AW-1] ? -$signed(div_quo) : $signed(div_quo);
        d_term = (AW'(err_q) - AW'(errp_q)) * $signed({24'h00_0000, derivative_time_i})
                 * $signed(AW'(pidsw_pkg::MS_PER_TIME_STEP));
        pid    = p_term + i_term + d_term;

        corr = pid;
        if (pid > $signed(AW'(up_eff))) corr = $signed(AW'(up_eff));
        else if (pid < -$signed(AW'(up_eff))) corr = -$signed(AW'(up_eff));
        psum = $signed(AW'(main_reference_i)) + corr;

        st_d       = st_q;
        err_d      = err_q;
        errp_d     = errp_q;
        integ_d    = integ_q;
        loop_out_d = loop_out_q;
        total_d    = total_q;
        corr_d     = process_correction_output_o;
        sat_d      = sat_q;
        case (st_q)
            pidsw_pkg::PIDSW_ST_IDLE: begin
                if (tick) begin
                    errp_d = err_q;
                    err_d  = err_now;
                    // anti-windup: hold the sum while pinned at a limit, asleep or bypassed
                    if (!sat_q && !asleep_o && !bypass_o)
                        integ_d = integ_q + AW'(err_now);
                    st_d = pidsw_pkg::PIDSW_ST_START;
                end
            end
            pidsw_pkg::PIDSW_ST_START: st_d = pidsw_pkg::PIDSW_ST_DIV;
            pidsw_pkg::PIDSW_ST_DIV: begin
                if (div_done) begin
                    st_d = pidsw_pkg::PIDSW_ST_IDLE;
                    if (pid < $signed(AW'(output_lower_limit_i))) begin
                        loop_out_d = output_lower_limit_i;
                    end else if (pid > $signed(AW'(up_eff))) begin
                        loop_out_d = up_eff;
                    end else begin
                        loop_out_d = pid[15:0];
                    end
                    corr_d = corr[15:0];
                    if (psum < $signed(AW'(output_lower_limit_i)))
                        total_d = output_lower_limit_i;
                    else if (psum > $signed(AW'(maximum_frequency_setting_i)))
                        total_d = maximum_frequency_setting_i;
                    else
                        total_d = psum[15:0];
                    sat_d = loop_mode_select_i ? (corr != pid) :
                            (pid < $signed(AW'(output_lower_limit_i)) ||
                             pid > $signed(AW'(up_eff)));
                end
            end
            default: st_d = pidsw_pkg::PIDSW_ST_IDLE;
        endcase
        if (!loop_enable_select_i) begin
            st_d    = pidsw_pkg::PIDSW_ST_IDLE;
            integ_d = '0;
            // park at the floor so a fresh enable in normal mode never shows an unclamped output; total_q is not parked
            loop_out_d = output_lower_limit_i;
            err_d   = '0;
            errp_d  = '0;
            sat_d   = 1'b0;
        end

        // sleep and wake
        loop_freq  = loop_mode_select_i ? total_q : loop_out_q;
        delay_ms   = 24'(sleep_delay_i) * 24'(pidsw_pkg::MS_PER_SLEEP_STEP);
        sleep_cond = loop_enable_select_i && run_cmd_i && !bypass_o &&
                     (loop_freq <= sleep_frequency_i);
        sleep_cnt_d = sleep_cnt_q;
        asleep_d    = asleep_o;
        if (!run_cmd_i || !loop_enable_select_i) begin
            asleep_d    = 1'b0;
            sleep_cnt_d = 24'h00_0000;
        end else if (asleep_o) begin
            if (dev > EW'(wake_hz)) asleep_d = 1'b0;
        end else if (!sleep_cond) begin
            sleep_cnt_d = 24'h00_0000;
        end else if (tick) begin
            if (sleep_cnt_q >= delay_ms) begin
                asleep_d    = 1'b1;
                sleep_cnt_d = 24'h00_0000;
            end else begin
                sleep_cnt_d = sleep_cnt_q + 24'h00_0001;
            end
        end

        // output selection
        if (!run_cmd_i || asleep_o) out_d = 16'h0000;
        else if (!loop_enable_select_i) out_d = main_reference_i;
        else if (bypass_o) out_d = loop_mode_select_i ? main_reference_i : sp_hz;
        else out_d = loop_freq;
        mon_d = bypass_o ? out_d : fbval_d;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q        <= pidsw_pkg::PIDSW_ST_IDLE;
            err_q       <= '0;
            errp_q      <= '0;
            integ_q     <= '0;
            loop_out_q  <= 16'h0000;
            total_q     <= 16'h0000;
            sat_q       <= 1'b0;
            sleep_cnt_q <= 24'h00_0000;
            asleep_o    <= 1'b0;
            bypass_o    <= 1'b0;
            out_freq_o  <= 16'h0000;
            monitor_o   <= 16'h0000;
            loop_feedback_value_o       <= 16'h0000;
            process_correction_output_o <= 16'h0000;
        end else begin
            st_q        <= st_d;
            err_q       <= err_d;
            errp_q      <= errp_d;
            integ_q     <= integ_d;
            loop_out_q  <= loop_out_d;
            total_q     <= total_d;
            sat_q       <= sat_d;
            sleep_cnt_q <= sleep_cnt_d;
            asleep_o    <= asleep_d;
            bypass_o    <= bypass_d;
            out_freq_o  <= out_d;
            monitor_o   <= mon_d;
            loop_feedback_value_o       <= fbval_d;
            process_correction_output_o <= corr_d;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_bypass_run;
        loop_enable_select_i && bypass_o && run_cmd_i && !asleep_o;
    endsequence
    sequence s_settled;
        loop_enable_select_i && st_q == pidsw_pkg::PIDSW_ST_IDLE;
    endsequence

    a_enable_gate: assert property (!loop_enable_select_i |=> integ_q == '0)
        else $error("integral kept while loop disabled");
    a_normal_clamp: assert property (s_settled ##0 !loop_mode_select_i |->
        loop_out_q >= $past(output_lower_limit_i) || $changed(output_lower_limit_i))
        else $error("normal output below lower limit");
    a_process_sum: assert property (div_done && loop_enable_select_i |=>
        total_q <= maximum_frequency_setting_i && total_q >= output_lower_limit_i)
        else $error("process sum out of range");
    a_bypass_norm: assert property (s_bypass_run ##0 !loop_mode_select_i |=>
        out_freq_o == $past(sp_hz)) else $error("bypass output not command");
    a_bypass_proc: assert property (s_bypass_run ##0 loop_mode_select_i |=>
        out_freq_o == $past(main_reference_i)) else $error("bypass output not main");
    a_stop_cancel: assert property (!run_cmd_i |=> !asleep_o && out_freq_o == 16'h0000)
        else $error("stop did not cancel sleep");
    a_wake_level: assert property (asleep_o && run_cmd_i && loop_enable_select_i &&
        dev > EW'(wake_hz) |=> !asleep_o) else $error("no wake on deviation");
    a_sleep_out: assert property ($rose(asleep_o) |-> out_freq_o != 16'h0000 ##1
        !asleep_o || out_freq_o == 16'h0000) else $error("output on while asleep");
    a_mon_bypass: assert property (bypass_o |=> monitor_o == out_freq_o)
        else $error("monitor shows feedback in bypass");
    a_windup_hold: assert property (tick && sat_q && loop_enable_select_i &&
        st_q == pidsw_pkg::PIDSW_ST_IDLE |=> $stable(integ_q))
        else $error("integral grew at limit");
endmodule : pidsw_core
`default_nettype wire

/* test/pidsw_fb_model.sv */
/* pidsw_fb_model: process feedback transmitter, analog and serial.
   assumes: the bench sets the process level in 0.1 % on the core clock. */
`timescale 1ns/1ps
`default_nettype none
module pidsw_fb_model (
    input  wire logic        core_clk_i,
    input  wire logic [15:0] level_i,
    output logic [15:0]      cur_o,
    output logic [15:0]      volt_o,
    output logic [15:0]      ser_o
);
    // distinct offsets show which source the loop took
    always_ff @(posedge core_clk_i) begin
        cur_o  <= level_i;
        volt_o <= level_i + 16'h0001;
        ser_o  <= level_i + 16'h0002;
    end
endmodule : pidsw_fb_model
`default_nettype wire

/* test/pidsw_core_tb.sv */
/* pidsw_core_tb: self-checking bench of the pid loop core.
   assumes: pidsw_pkg, pidsw_core and pidsw_fb_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module pidsw_core_tb;
    logic        clk, rst_n, en, mode, pct, run, slp, byp, srst;
    logic [1:0]  fsel;
    logic [2:0]  ssel;
    logic [4:0]  pins;
    logic [24:0] tfun;
    logic [15:0] sp, esp, mref, maxf, ul, ll, sd, sf, wl, lvl, cur, volt, ser;
    logic [15:0] out, corr, fbv, mon;
    int          n_errors, check_count;

    pidsw_fb_model fb (.core_clk_i(clk), .level_i(lvl), .cur_o(cur), .volt_o(volt), .ser_o(ser));
    // short sample period keeps the run brief
    pidsw_core #(.SAMPLE_CYCLES(20)) dut (
        .core_clk_i(clk), .resetn_i(rst_n), .sync_reset_i(srst),
        .loop_enable_select_i(en), .loop_mode_select_i(mode), .unit_scale_select_i(pct),
        .feedback_source_select_i(fsel), .setpoint_source_select_i(ssel),
        .loop_setpoint_i(sp), .ext_setpoint_i(esp), .main_reference_i(mref),
        .maximum_frequency_setting_i(maxf), .current_or_voltage_input_i(cur),
        .voltage_input_i(volt), .serial_feedback_i(ser),
        .proportional_gain_i(16'h0BB8), .integral_time_i(16'h0064),
        .derivative_time_i(16'h0000), .output_upper_limit_i(ul),
        .output_lower_limit_i(ll), .sleep_delay_i(sd), .sleep_frequency_i(sf),
        .wake_level_i(wl), .multi_function_inputs_i(pins),
        .input_terminal_function_i(tfun), .run_cmd_i(run), .out_freq_o(out),
        .process_correction_output_o(corr), .loop_feedback_value_o(fbv),
        .monitor_o(mon), .asleep_o(slp), .bypass_o(byp));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task test_done;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [15:0] pick(input int s);
        return (s == 0) ? out : (s == 1) ? {15'h0000, slp} : fbv;
    endfunction : pick

    // bounded wait on out (0), asleep (1) or feedback (2); a timeout ends the run
    task automatic wait_on(input int s, input logic [15:0] exp);
        for (int i = 0; i < 6000 && pick(s) !== exp; i++) @(negedge clk);
        chk(pick(s), exp);
        if (pick(s) !== exp) test_done();
    endtask : wait_on

    task t_off_stop;
        @(negedge clk);
        mref = 16'h0BB8;
        wait_on(0, 16'h0BB8);
        run = 1'b0;
        wait_on(0, 16'h0000);
        chk({15'h0000, slp}, 16'h0000);
        run = 1'b1;
        $display("disabled and stop done");
    endtask : t_off_stop

    task t_bypass;
        @(negedge clk);
        en = 1'b1;
        tfun[14:10] = pidsw_pkg::FUNC_LOOP_BYPASS;
        pins = 5'h04;
        sp = 16'h04D2;
        wait_on(0, 16'h04D2);
        chk(mon, 16'h04D2);
        chk({15'h0000, byp}, 16'h0001);
        ssel = 3'h3;
        wait_on(0, 16'h0100);
        ssel = 3'h0;
        pct = 1'b1;
        sp = 16'h01F4;
        wait_on(0, 16'h0BB8);
        mode = 1'b1;
        mref = 16'h07D0;
        wait_on(0, 16'h07D0);
        pins = 5'h00;
        mode = 1'b0;
        $display("bypass done");
    endtask : t_bypass

    task t_fb_src;
        @(negedge clk);
        lvl = 16'h0190;
        for (int s = 0; s < 4; s++) begin
            fsel = s[1:0];
            wait_on(2, 16'h0190 + ((s < 2) ? 16'h0000 : 16'(s - 1)));
        end
        chk(mon, 16'h0192);
        fsel = 2'h2;
        $display("feedback source done");
    endtask : t_fb_src

    task t_sync_reset;
        logic [15:0] held;
        @(negedge clk);
        srst = 1'b1;
        repeat (60) @(negedge clk);
        held = out;
        sp = 16'h0000;
        repeat (200) @(negedge clk);
        chk(out, held);
        srst = 1'b0;
        wait_on(0, 16'h0032);
        $display("sync reset done");
    endtask : t_sync_reset

    task t_limits;
        @(negedge clk);
        pct = 1'b0;
        sp = 16'h1388;
        lvl = 16'h0000;
        wait_on(0, 16'h0FA0);
        sp = 16'h0000;
        lvl = 16'h03E8;
        wait_on(0, 16'h0032);
        mode = 1'b1;
        mref = 16'h1B58;
        sp = 16'h1388;
        lvl = 16'h0000;
        wait_on(0, 16'h1770);
        chk(corr, 16'h0FA0);
        mref = 16'h0000;
        sp = 16'h0000;
        lvl = 16'h03E8;
        wait_on(0, 16'h0032);
        repeat (100) @(negedge clk);
        chk(corr, 16'hF060);
        mode = 1'b0;
        $display("limits done");
    endtask : t_limits

    task t_sleep;
        @(negedge clk);
        sf = 16'h0032;
        sd = 16'h0001;
        wait_on(1, 16'h0001);
        wait_on(0, 16'h0000);
        sp = 16'h1388;
        lvl = 16'h0000;
        wait_on(1, 16'h0000);
        $display("sleep and wake done");
    endtask : t_sleep

    initial begin
        n_errors = 0;
        check_count = 0;
        {rst_n, en, mode, pct, run, srst, ssel, pins, tfun} = '0;
        esp = 16'h0100;
        fsel = 2'h2;
        {sp, mref, lvl, sf} = '0;
        maxf = 16'h1770;
        ul = 16'h0FA0;
        ll = 16'h0032;
        sd = 16'h0258;
        wl = 16'h015E;
        repeat (12) @(negedge clk);
        chk(out, 16'h0000);
        chk(mon, 16'h0000);
        rst_n = 1'b1;
        run = 1'b1;
        t_off_stop();
        t_bypass();
        t_fb_src();
        t_sync_reset();
        t_limits();
        t_sleep();
        test_done();
    end
endmodule : pidsw_core_tb
`default_nettype wire
